// *** verilog/sld_pkg.sv ***
/*
 * Shared constants for the safe speed limit and guard door lock logic.
 * Assumes a single 10 MHz system clock and synchronous active-high reset.
 */
package sld_pkg;
    // speed limit selector codes
    localparam logic [1:0] SEL_NONE   = 2'h0;
    localparam logic [1:0] SEL_PAIR_A = 2'h1;
    localparam logic [1:0] SEL_PAIR_B = 2'h2;

    // widths
    localparam int SPEED_W = 16;
    localparam int DELAY_W = 12;

    // lock delay range and factory value, in seconds
    localparam logic [11:0] DELAY_FACTORY = 12'h001;
    localparam logic [11:0] DELAY_MIN     = 12'h001;
    localparam logic [11:0] DELAY_MAX     = 12'hE10;

    // reset value of the speed limit outputs
    localparam logic [15:0] SPEED_RESET = 16'h0000;

    // timing: one tick per second at the system clock rate
    localparam int CLOCK_HZ          = 10_000_000;
    localparam int TICK_PERIOD_S     = 1;
    localparam int CYCLES_PER_SECOND = TICK_PERIOD_S * CLOCK_HZ;

    // lock sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h1,
        ST_COUNT   = 3'h2,
        ST_STOPPED = 3'h4
    } sld_state_t;
endpackage

// *** verilog/sld_tick.sv ***
/*
 * Restartable one-second tick generator.
 * Assumes i_restart is a one-cycle pulse synchronous to i_clock.
 */
module sld_tick #(
    parameter int CYCLES = sld_pkg::CYCLES_PER_SECOND
) (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // control
    input  wire logic i_restart,
    // tick pulse
    output logic      o_tick
);
    localparam int CW = $clog2(CYCLES);

    if (CYCLES < 2) begin : g_check
        $error("sld_tick: CYCLES must be at least 2");
    end

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          tick_reg;
    logic          tick_next;

    // restart aligns the first tick a full second after the stop event
    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (i_restart) begin
            cnt_next = '0;
        end else if (cnt_reg == CW'(CYCLES - 1)) begin
            cnt_next  = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign o_tick = tick_reg;
endmodule

// *** verilog/sld_top.sv ***
/*
 * Safe maximum speed selection and guard door lock delay sequencer.
 * Assumes all inputs synchronous to i_clock; stop events are one-cycle pulses.
 */
// Notes on behaviour
// - selector on pair A: both low picks low limit, both high picks high.
// - selector on pair B: both low picks low limit, both high picks high.
// - door lock assignment is no or yes; lock sequencing runs only when yes.
// - assigning yes is refused unless the first logic output is unassigned.
// - long delay in seconds, factory one, after torque off or normal ramp.
// - short delay in seconds, factory one, after a safe stop one ramp.
// - speed limit activation no makes the limit inactive, yes active.
// - selector not assigned always picks the low limit.
module sld_top #(
    parameter int CYCLES_PER_SECOND = sld_pkg::CYCLES_PER_SECOND
) (
    // clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_rst,
    // speed limit configuration
    input  wire logic                        i_speed_limit_activation,
    input  wire logic [1:0]                  i_speed_limit_selector,
    input  wire logic [sld_pkg::SPEED_W-1:0] i_speed_limit_low,
    input  wire logic [sld_pkg::SPEED_W-1:0] i_speed_limit_high,
    // safety logic input pairs
    input  wire logic                        i_input_pair_a_first,
    input  wire logic                        i_input_pair_a_second,
    input  wire logic                        i_input_pair_b_first,
    input  wire logic                        i_input_pair_b_second,
    // door lock configuration
    input  wire logic                        i_door_lock_assign_write,
    input  wire logic                        i_door_lock_assign_value,
    input  wire logic                        i_first_logic_output_assigned,
    input  wire logic                        i_delay_write,
    input  wire logic [sld_pkg::DELAY_W-1:0] i_door_lock_long_delay,
    input  wire logic [sld_pkg::DELAY_W-1:0] i_door_lock_short_delay,
    // stop events
    input  wire logic                        i_safe_torque_off_event,
    input  wire logic                        i_normal_ramp_event,
    input  wire logic                        i_safe_stop_one_event,
    // speed limit status
    output logic [sld_pkg::SPEED_W-1:0]      o_safe_max_speed,
    output logic                             o_speed_limit_active,
    output logic                             o_speed_limit_high_sel,
    // door lock status
    output logic                             o_door_lock_assignment,
    output logic                             o_door_lock_refused,
    output logic [sld_pkg::DELAY_W-1:0]      o_door_lock_long_delay,
    output logic [sld_pkg::DELAY_W-1:0]      o_door_lock_short_delay,
    output logic                             o_door_lock_waiting,
    output logic                             o_machine_stopped
);
    if (CYCLES_PER_SECOND < 2) begin : g_check
        $error("sld_top: CYCLES_PER_SECOND must be at least 2");
    end

    // keep a delay inside 1..3600 s so the countdown always terminates
    function automatic logic [sld_pkg::DELAY_W-1:0] clamp_delay(
        input logic [sld_pkg::DELAY_W-1:0] v);
        if (v < sld_pkg::DELAY_MIN) begin
            return sld_pkg::DELAY_MIN;
        end else if (v > sld_pkg::DELAY_MAX) begin
            return sld_pkg::DELAY_MAX;
        end
        return v;
    endfunction

    // returns {agree, level}; a pair in disagreement holds the last choice
    function automatic logic [1:0] pair_level(input logic a, input logic b);
        return {a == b, a & b};
    endfunction

    logic [sld_pkg::SPEED_W-1:0] speed_reg;
    logic [sld_pkg::SPEED_W-1:0] speed_next;
    logic                        active_reg;
    logic                        active_next;
    logic                        high_sel_reg;
    logic                        high_sel_next;
    logic [1:0]                  pair_a;
    logic [1:0]                  pair_b;

    assign pair_a = pair_level(i_input_pair_a_first, i_input_pair_a_second);
    assign pair_b = pair_level(i_input_pair_b_first, i_input_pair_b_second);

    // speed limit selection
    always_comb begin
        high_sel_next = high_sel_reg;
        if (i_speed_limit_selector == sld_pkg::SEL_PAIR_A) begin
            if (pair_a[1]) high_sel_next = pair_a[0];
        end else if (i_speed_limit_selector == sld_pkg::SEL_PAIR_B) begin
            if (pair_b[1]) high_sel_next = pair_b[0];
        end else begin
            high_sel_next = 1'b0;
        end
        active_next = i_speed_limit_activation;
        speed_next  = high_sel_next ? i_speed_limit_high : i_speed_limit_low;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            speed_reg    <= sld_pkg::SPEED_RESET;
            active_reg   <= 1'b0;
            high_sel_reg <= 1'b0;
        end else begin
            speed_reg    <= speed_next;
            active_reg   <= active_next;
            high_sel_reg <= high_sel_next;
        end
    end

    // door lock configuration state
    logic                        assign_reg;
    logic                        assign_next;
    logic                        refused_reg;
    logic                        refused_next;
    logic [sld_pkg::DELAY_W-1:0] long_reg;
    logic [sld_pkg::DELAY_W-1:0] long_next;
    logic [sld_pkg::DELAY_W-1:0] short_reg;
    logic [sld_pkg::DELAY_W-1:0] short_next;

    // the long-above-short advice is not enforced: both values are only clamped to 1..3600
    always_comb begin
        assign_next  = assign_reg;
        refused_next = 1'b0;
        long_next    = long_reg;
        short_next   = short_reg;
        if (i_door_lock_assign_write) begin
            if (i_door_lock_assign_value && i_first_logic_output_assigned) begin
                refused_next = 1'b1;
            end else begin
                assign_next = i_door_lock_assign_value;
            end
        end
        if (i_delay_write) begin
            long_next  = clamp_delay(i_door_lock_long_delay);
            short_next = clamp_delay(i_door_lock_short_delay);
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            assign_reg  <= 1'b0;
            refused_reg <= 1'b0;
            long_reg    <= sld_pkg::DELAY_FACTORY;
            short_reg   <= sld_pkg::DELAY_FACTORY;
        end else begin
            assign_reg  <= assign_next;
            refused_reg <= refused_next;
            long_reg    <= long_next;
            short_reg   <= short_next;
        end
    end

    // lock delay sequencer
    sld_pkg::sld_state_t         state_reg;
    sld_pkg::sld_state_t         state_next;
    logic [sld_pkg::DELAY_W-1:0] count_reg;
    logic [sld_pkg::DELAY_W-1:0] count_next;
    logic                        long_trig;
    logic                        short_trig;
    logic                        tick;

    // a long and a short event together take the long delay, the safer wait
    assign long_trig  = assign_reg & (i_safe_torque_off_event | i_normal_ramp_event);
    assign short_trig = assign_reg & i_safe_stop_one_event;

    sld_tick #(
        .CYCLES    (CYCLES_PER_SECOND)
    ) i_sld_tick (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_restart (long_trig | short_trig),
        .o_tick    (tick)
    );

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            sld_pkg::ST_COUNT: begin
                if (tick) begin
                    if (count_reg <= sld_pkg::DELAY_MIN) begin
                        state_next = sld_pkg::ST_STOPPED;
                        count_next = '0;
                    end else begin
                        count_next = count_reg - sld_pkg::DELAY_MIN;
                    end
                end
            end
            default: begin
            end
        endcase
        if (long_trig) begin
            state_next = sld_pkg::ST_COUNT;
            count_next = long_reg;
        end else if (short_trig) begin
            state_next = sld_pkg::ST_COUNT;
            count_next = short_reg;
        end
        if (!assign_reg) begin
            state_next = sld_pkg::ST_IDLE;
            count_next = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg <= sld_pkg::ST_IDLE;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    assign o_safe_max_speed        = speed_reg;
    assign o_speed_limit_active    = active_reg;
    assign o_speed_limit_high_sel  = high_sel_reg;
    assign o_door_lock_assignment  = assign_reg;
    assign o_door_lock_refused     = refused_reg;
    assign o_door_lock_long_delay  = long_reg;
    assign o_door_lock_short_delay = short_reg;
    assign o_door_lock_waiting     = (state_reg == sld_pkg::ST_COUNT);
    assign o_machine_stopped       = (state_reg == sld_pkg::ST_STOPPED);

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_pair_a_high: assert property (
        i_speed_limit_selector == sld_pkg::SEL_PAIR_A && i_input_pair_a_first
        && i_input_pair_a_second |=> o_speed_limit_high_sel
        && o_safe_max_speed == $past(i_speed_limit_high))
        else $error("pair A high did not select high limit");
    a_pair_a_low: assert property (
        i_speed_limit_selector == sld_pkg::SEL_PAIR_A && !i_input_pair_a_first
        && !i_input_pair_a_second |=> !o_speed_limit_high_sel)
        else $error("pair A low did not select low limit");
    a_pair_b_sel: assert property (
        i_speed_limit_selector == sld_pkg::SEL_PAIR_B
        && i_input_pair_b_first == i_input_pair_b_second
        |=> o_speed_limit_high_sel == $past(i_input_pair_b_first))
        else $error("pair B level not followed");
    a_none_low: assert property (
        i_speed_limit_selector == sld_pkg::SEL_NONE
        |=> !o_speed_limit_high_sel && o_safe_max_speed == $past(i_speed_limit_low))
        else $error("unassigned selector did not use low limit");
    a_active_follow: assert property (
        ##1 o_speed_limit_active == $past(i_speed_limit_activation))
        else $error("activation not reflected");
    a_unassigned_idle: assert property (
        !o_door_lock_assignment |=> !o_door_lock_waiting && !o_machine_stopped)
        else $error("lock sequencer ran while unassigned");
    a_refuse_assign: assert property (
        i_door_lock_assign_write && i_door_lock_assign_value
        && i_first_logic_output_assigned
        |=> o_door_lock_refused && $stable(o_door_lock_assignment))
        else $error("assignment accepted while output one in use");
    a_long_reload: assert property (
        long_trig |=> o_door_lock_waiting && count_reg == $past(long_reg))
        else $error("long delay not loaded");
    a_short_reload: assert property (
        short_trig && !long_trig |=> o_door_lock_waiting && count_reg == $past(short_reg))
        else $error("short delay not loaded");
    a_tick_count: assert property (
        o_door_lock_waiting && !tick && !long_trig && !short_trig && assign_reg
        |=> $stable(count_reg) && o_door_lock_waiting)
        else $error("count moved without a tick");
    a_tick_expire: assert property (
        o_door_lock_waiting && tick && count_reg == 12'h001 && assign_reg
        && !long_trig && !short_trig |=> o_machine_stopped)
        else $error("final tick did not end the wait");
endmodule

// *** verification/sld_partner.sv ***
/*
 * Far-side model: safety input pairs, stop event source, door actuator.
 * Assumes the bench changes its commands 1 ns after a rising clock edge.
 */
module sld_partner (
    // clock
    input  wire logic       i_clock,
    // commands from the bench
    input  wire logic       i_pair_a_level,
    input  wire logic       i_pair_b_level,
    input  wire logic       i_stop_req,
    input  wire logic [1:0] i_stop_kind,
    input  wire logic       i_machine_stopped,
    // toward the drive
    output logic            o_pair_a_first,
    output logic            o_pair_a_second,
    output logic            o_pair_b_first,
    output logic            o_pair_b_second,
    output logic            o_sto_event,
    output logic            o_ramp_event,
    output logic            o_ss1_event,
    // door actuator state
    output logic            o_door_released
);
    timeunit 1ns;
    timeprecision 1ns;
    logic req_reg;
    logic pulse;

    // both inputs of a pair read the same level; no skew modelled
    assign o_pair_a_first  = i_pair_a_level;
    assign o_pair_a_second = i_pair_a_level;
    assign o_pair_b_first  = i_pair_b_level;
    assign o_pair_b_second = i_pair_b_level;

    // a held request becomes one event pulse, so long requests never retrigger
    always_ff @(posedge i_clock) begin
        req_reg <= i_stop_req;
    end
    assign pulse        = i_stop_req & ~req_reg;
    assign o_sto_event  = pulse & (i_stop_kind == 2'h0);
    assign o_ramp_event = pulse & (i_stop_kind == 2'h1);
    assign o_ss1_event  = pulse & (i_stop_kind == 2'h2);

    // the door may open only once the drive reports the machine stopped
    assign o_door_released = i_machine_stopped;
endmodule

// *** verification/test_safe_speed_limit_door_lock.sv ***
/*
 * Self-checking bench for the speed limit selection and door lock sequencer.
 * Assumes a 10 MHz clock and a shortened second of CPS cycles.
 */
module test_safe_speed_limit_door_lock;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CPS   = 8;
    localparam int LIMIT = 2000;
    logic        i_clock = 1'b0;
    logic        i_rst   = 1'b1;
    logic        act     = 1'b0;
    logic [1:0]  sel     = 2'h0;
    logic [15:0] lim_lo  = 16'h0123;
    logic [15:0] lim_hi  = 16'hABCD;
    logic        lvl_a   = 1'b0;
    logic        lvl_b   = 1'b0;
    logic        asg_wr  = 1'b0;
    logic        asg_val = 1'b0;
    logic        lo1     = 1'b0;
    logic        dly_wr  = 1'b0;
    logic [11:0] long_d  = 12'h001;
    logic [11:0] short_d = 12'h001;
    logic        req     = 1'b0;
    logic [1:0]  kind    = 2'h0;
    logic        a1, a2, b1, b2, safe_torque_off, ramp, ss1, released;
    logic [15:0] speed;
    logic [11:0] long_q, short_q;
    logic        active, hi_sel, assigned, refused, waiting, stopped;
    int          error_cnt       = 0;
    int          samples_checked = 0;
    int          cycle_cnt       = 0;

    sld_partner i_sld_partner (.i_clock(i_clock), .i_pair_a_level(lvl_a),
        .i_pair_b_level(lvl_b), .i_stop_req(req), .i_stop_kind(kind),
        .i_machine_stopped(stopped), .o_pair_a_first(a1), .o_pair_a_second(a2),
        .o_pair_b_first(b1), .o_pair_b_second(b2), .o_sto_event(safe_torque_off),
        .o_ramp_event(ramp), .o_ss1_event(ss1), .o_door_released(released));

    sld_top #(.CYCLES_PER_SECOND(CPS)) i_sld_top (.i_clock(i_clock), .i_rst(i_rst),
        .i_speed_limit_activation(act), .i_speed_limit_selector(sel),
        .i_speed_limit_low(lim_lo), .i_speed_limit_high(lim_hi),
        .i_input_pair_a_first(a1), .i_input_pair_a_second(a2),
        .i_input_pair_b_first(b1), .i_input_pair_b_second(b2),
        .i_door_lock_assign_write(asg_wr), .i_door_lock_assign_value(asg_val),
        .i_first_logic_output_assigned(lo1), .i_delay_write(dly_wr),
        .i_door_lock_long_delay(long_d), .i_door_lock_short_delay(short_d),
        .i_safe_torque_off_event(safe_torque_off), .i_normal_ramp_event(ramp),
        .i_safe_stop_one_event(ss1), .o_safe_max_speed(speed),
        .o_speed_limit_active(active), .o_speed_limit_high_sel(hi_sel),
        .o_door_lock_assignment(assigned), .o_door_lock_refused(refused),
        .o_door_lock_long_delay(long_q), .o_door_lock_short_delay(short_q),
        .o_door_lock_waiting(waiting), .o_machine_stopped(stopped));

    // clock at 100 ns period
    always #50 i_clock = ~i_clock;

    // inputs always move 1 ns after the edge, so no race with the design
    task automatic step();
        @(posedge i_clock);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic fire(input logic [1:0] k);
        kind = k;
        req  = 1'b1;
        step();
        req  = 1'b0;
    endtask

    // waiting rises at the event edge; stopped follows secs seconds plus one cycle
    task automatic stop_time(input logic [1:0] k, input int secs);
        int n;
        n = 0;
        fire(k);
        check(waiting, 1'b1, "waiting after event");
        while (stopped !== 1'b1 && n < 1000) begin
            step();
            n++;
        end
        // the registered tick lands one cycle after each counted second
        check(16'(n), 16'(secs * CPS + 1), "stop delay");
        check(released, 1'b1, "door released");
    endtask

    task automatic assign_write(input logic v, input logic lo1_v);
        asg_val = v;
        lo1     = lo1_v;
        asg_wr  = 1'b1;
        step();
        asg_wr  = 1'b0;
    endtask

    task automatic delay_write(input logic [11:0] l, input logic [11:0] s);
        long_d  = l;
        short_d = s;
        dly_wr  = 1'b1;
        step();
        dly_wr  = 1'b0;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard: runs well past the expected 128 cycles
    always @(posedge i_clock) begin
        cycle_cnt++;
        if (cycle_cnt == LIMIT) begin
            error_cnt++;
            $display("MISMATCH at %0t: timeout", $time);
            print_verdict();
        end
    end

    // each row: selector, pair a level, pair b level, high limit expected
    logic [4:0] rows [6] = '{5'b00_1_1_0, 5'b01_0_1_0, 5'b01_1_0_1, 5'b10_1_0_0,
                             5'b10_0_1_1, 5'b11_1_1_0};

    // main sequence
    initial begin
        repeat (8) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        check(long_q, 16'h0001, "long factory");
        check(short_q, 16'h0001, "short factory");
        check(assigned, 1'b0, "assignment at reset");
        check(active, 1'b0, "activation at reset");
        $display("test reset done");
        act = 1'b1;
        step();
        check(active, 1'b1, "activation yes");
        // the other pair is driven opposite to catch a swapped pair
        foreach (rows[i]) begin
            {sel, lvl_a, lvl_b} = rows[i][4:1];
            step();
            step();
            check(speed, rows[i][0] ? lim_hi : lim_lo, "limit value");
            check(hi_sel, rows[i][0], "high select");
        end
        act = 1'b0;
        step();
        check(active, 1'b0, "activation no");
        $display("test speed done");
        delay_write(12'h000, 12'hFA0);
        check(long_q, 16'h0001, "long clamp");
        check(short_q, 16'h0E10, "short clamp");
        // the strobe rests low for one edge so two writes stay distinct
        step();
        delay_write(12'h003, 12'h002);
        check(long_q, 16'h0003, "long stored");
        check(short_q, 16'h0002, "short stored");
        fire(2'h0);
        repeat (3) step();
        check(waiting, 1'b0, "unassigned ignores stop");
        assign_write(1'b1, 1'b1);
        check(refused, 1'b1, "refused flag");
        check(assigned, 1'b0, "assignment kept");
        step();
        assign_write(1'b1, 1'b0);
        check(assigned, 1'b1, "assignment taken");
        check(refused, 1'b0, "no refusal");
        $display("test assignment done");
        stop_time(2'h0, 3);
        stop_time(2'h1, 3);
        stop_time(2'h2, 2);
        fire(2'h0);
        repeat (5) step();
        stop_time(2'h2, 2);
        assign_write(1'b0, 1'b1);
        step();
        check(stopped, 1'b0, "unassign clears");
        check(assigned, 1'b0, "unassigned");
        $display("test lock delays done");
        print_verdict();
    end
endmodule
